// file: psrm_regs.svh
// Constants for the power-state and reset manager: timing counts and encodings.
// Assumes a 125 MHz system clock; included by bare name from the package users.
`ifndef PSRM_REGS_SVH
`define PSRM_REGS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PSRM_CLK_MHZ 125
`define PSRM_RST_LOW_MIN_US 214
`define PSRM_RST_LOW_CYC ((`PSRM_RST_LOW_MIN_US * `PSRM_CLK_MHZ))
`define PSRM_SUPPLY_SETTLE_MS 5
`define PSRM_SUPPLY_SETTLE_CYC ((`PSRM_SUPPLY_SETTLE_MS * 1000 * `PSRM_CLK_MHZ))
`define PSRM_OSC_MASK_CYC 1024
`define PSRM_INIT_CYC 64
`define PSRM_DRAM_IDLE_CYC 256

// ----------------------------------------------------------------------------
// Command codes on the host command port
// ----------------------------------------------------------------------------
`define PSRM_CMD_ACTIVE 2'h0
`define PSRM_CMD_STANDBY 2'h1
`define PSRM_CMD_SLEEP 2'h2
`define PSRM_CMD_POWERDOWN 2'h3

`endif

// file: psrm_pkg.sv
// Types shared by both ends of the power-state and reset manager link.
// Assumes psrm_regs.svh sits in the same folder.
`default_nettype none
`include "psrm_regs.svh"

package psrm_pkg;
    // One-hot power states.
    typedef enum logic [4:0] {
        PSRM_ST_INIT = 5'h01,
        PSRM_ST_ACTIVE = 5'h02,
        PSRM_ST_STANDBY = 5'h04,
        PSRM_ST_SLEEP = 5'h08,
        PSRM_ST_PDOWN = 5'h10
    } psrm_state_e;
    typedef logic [1:0] psrm_cmd_t;
endpackage

`default_nettype wire

// file: psrm_link_if.sv
// Link between the host controller and the power-state manager: reset pin and command strobe.
// Assumes one shared clock; the testbench instantiates it and joins both ends.
`default_nettype none

interface psrm_link_if;
    logic rst_pin_n;
    logic cmd_valid;
    logic [1:0] cmd_code;
    logic cmd_ready;
    modport dev (input rst_pin_n, input cmd_valid, input cmd_code, output cmd_ready);
    modport host (output rst_pin_n, output cmd_valid, output cmd_code, input cmd_ready);
endinterface

`default_nettype wire

// file: psrm_pulse_filter.sv
// Low-pulse qualifier: asserts when its input has stayed low for MIN_CYC clock cycles.
// Assumes the input is synchronous to clk.
`default_nettype none

module psrm_pulse_filter #(
    parameter int MIN_CYC = 26750
) (
    input wire logic clk,       // System clock.
    input wire logic reset_n,   // Asynchronous reset, active low.
    input wire logic level_n,   // Watched level, active low.
    output logic qualified      // High while the low level has lasted MIN_CYC cycles.
);
    localparam int CW = $clog2(MIN_CYC + 1);

    initial begin
        if (MIN_CYC < 1) begin
            $error("psrm_pulse_filter: MIN_CYC must be at least one.");
        end
    end

    logic [CW-1:0] count;

    // ------------------------------------------------------------------------
    // Low-time counter
    // ------------------------------------------------------------------------
    // Count low cycles, saturating at the threshold; any high cycle restarts.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (level_n) begin
            count <= '0;
        end else if (count != CW'(MIN_CYC)) begin
            count <= count + CW'(1);
        end
    end

    assign qualified = (count == CW'(MIN_CYC));
endmodule

`default_nettype wire

// file: psrm_device.sv
// Device end of the power-state and reset manager.
// Assumes the host drives the link synchronously to clk and that clk is the oscillator clock.
`default_nettype none
`include "psrm_regs.svh"

module psrm_device
    import psrm_pkg::*;
#(
    parameter int RST_LOW_CYC = `PSRM_RST_LOW_CYC,
    parameter int OSC_MASK_CYC = `PSRM_OSC_MASK_CYC,
    parameter int INIT_CYC = `PSRM_INIT_CYC,
    parameter int DRAM_IDLE_CYC = `PSRM_DRAM_IDLE_CYC
) (
    input wire logic clk,            // System clock.
    input wire logic reset_n,        // Internal power-on reset, active low.
    psrm_link_if.dev link,           // Link to the host.
    input wire logic dram_busy,      // Memory traffic present this cycle.
    output logic core_reset_n,       // Chip-wide core reset, active low.
    output logic osc_ready,          // Oscillator clock usable.
    output logic sys_clk_en,         // Core engine clock enable.
    output logic engines_en,         // Graphics, audio and touch engines enabled.
    output logic engines_rst_n,      // Core engines held in reset when low.
    output logic engines_pwr_on,     // Core engine power domain switched on.
    output logic dram_pd,            // DRAM in active power-down.
    output logic dram_self_refresh,  // DRAM in self-refresh.
    output logic ddr_if_en,          // DDR interface enabled.
    output logic pll_en,             // All PLLs enabled.
    output logic regs_clear,         // One-cycle clear of non-system registers.
    output logic pins_hold,          // Pins keep their last state.
    output logic host_if_en,         // Host command interface alive.
    output logic regulator_on,       // Internal core regulator on.
    output psrm_state_e state        // Present power state.
);
    initial begin
        if (RST_LOW_CYC < 1 || OSC_MASK_CYC < 1 || INIT_CYC < 1 || DRAM_IDLE_CYC < 1) begin
            $error("psrm_device: counts must be at least one.");
        end
    end

    localparam int OW = $clog2(OSC_MASK_CYC + INIT_CYC + 1);
    localparam int DW = $clog2(DRAM_IDLE_CYC + 1);

    logic pin_reset;
    logic chip_rst_n;
    logic [OW-1:0] boot_count;
    logic [DW-1:0] idle_count;
    psrm_state_e next_state;

    // ------------------------------------------------------------------------
    // Reset combination
    // ------------------------------------------------------------------------
    // Qualify the reset pin low time before it may reset the chip.
    psrm_pulse_filter #(.MIN_CYC(RST_LOW_CYC)) u_pin_filter (
        .clk(clk),
        .reset_n(reset_n),
        .level_n(link.rst_pin_n),
        .qualified(pin_reset)
    );

    // A qualified pin reset and power-on reset reach the same targets.
    assign chip_rst_n = reset_n & ~pin_reset;

    // Registered core reset; asserts asynchronously, releases on clock.
    always_ff @(posedge clk or negedge chip_rst_n) begin
        if (!chip_rst_n) begin
            core_reset_n <= 1'b0;
        end else begin
            core_reset_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Oscillator mask and power-up initialization
    // ------------------------------------------------------------------------
    // Count the mask period, then the initialization period, after reset release.
    always_ff @(posedge clk or negedge core_reset_n) begin
        if (!core_reset_n) begin
            boot_count <= '0;
        end else if (boot_count != OW'(OSC_MASK_CYC + INIT_CYC)) begin
            boot_count <= boot_count + OW'(1);
        end
    end

    assign osc_ready = (boot_count >= OW'(OSC_MASK_CYC));

    // ------------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------------
    // Commands are taken only once initialization has finished.
    assign link.cmd_ready = (state != PSRM_ST_INIT);

    // Choose the next state from the present one and any accepted command.
    always_comb begin
        next_state = state;
        unique case (state)
            PSRM_ST_INIT: begin
                if (boot_count == OW'(OSC_MASK_CYC + INIT_CYC)) begin
                    next_state = PSRM_ST_SLEEP;
                end
            end
            PSRM_ST_ACTIVE, PSRM_ST_STANDBY, PSRM_ST_SLEEP, PSRM_ST_PDOWN: begin
                if (link.cmd_valid) begin
                    unique case (link.cmd_code)
                        `PSRM_CMD_ACTIVE: next_state = PSRM_ST_ACTIVE;
                        `PSRM_CMD_STANDBY: next_state = PSRM_ST_STANDBY;
                        `PSRM_CMD_SLEEP: next_state = PSRM_ST_SLEEP;
                        `PSRM_CMD_POWERDOWN: next_state = PSRM_ST_PDOWN;
                    endcase
                end
            end
            default: next_state = PSRM_ST_INIT;
        endcase
    end

    // State register; same-state commands leave it as it is.
    always_ff @(posedge clk or negedge core_reset_n) begin
        if (!core_reset_n) begin
            state <= PSRM_ST_INIT;
        end else begin
            state <= next_state;
        end
    end

    // Clear non-system registers only on a genuine entry to POWERDOWN.
    always_ff @(posedge clk or negedge core_reset_n) begin
        if (!core_reset_n) begin
            regs_clear <= 1'b0;
        end else begin
            regs_clear <= (next_state == PSRM_ST_PDOWN) && (state != PSRM_ST_PDOWN);
        end
    end

    // ------------------------------------------------------------------------
    // DRAM idle timer in STANDBY
    // ------------------------------------------------------------------------
    // Count idle memory cycles; traffic or leaving STANDBY restarts the count.
    always_ff @(posedge clk or negedge core_reset_n) begin
        if (!core_reset_n) begin
            idle_count <= '0;
        end else if (state != PSRM_ST_STANDBY || dram_busy) begin
            idle_count <= '0;
        end else if (idle_count != DW'(DRAM_IDLE_CYC)) begin
            idle_count <= idle_count + DW'(1);
        end
    end

    // ------------------------------------------------------------------------
    // Per-state controls
    // ------------------------------------------------------------------------
    // Registered controls follow the state; nothing here clears retained registers.
    always_ff @(posedge clk or negedge core_reset_n) begin
        if (!core_reset_n) begin
            sys_clk_en <= 1'b0;
            engines_en <= 1'b0;
            engines_rst_n <= 1'b0;
            engines_pwr_on <= 1'b0;
            dram_pd <= 1'b0;
            dram_self_refresh <= 1'b0;
            ddr_if_en <= 1'b0;
            pll_en <= 1'b0;
            pins_hold <= 1'b0;
            host_if_en <= 1'b0;
            regulator_on <= 1'b1;
        end else begin
            sys_clk_en <= (next_state == PSRM_ST_ACTIVE);
            engines_en <= (next_state == PSRM_ST_ACTIVE);
            engines_rst_n <= (next_state != PSRM_ST_PDOWN) && (next_state != PSRM_ST_INIT);
            engines_pwr_on <= (next_state != PSRM_ST_PDOWN);
            dram_pd <= (state == PSRM_ST_STANDBY) && (next_state == PSRM_ST_STANDBY) && !dram_busy
                       && (idle_count == DW'(DRAM_IDLE_CYC));
            dram_self_refresh <= (next_state == PSRM_ST_SLEEP);
            ddr_if_en <= (next_state == PSRM_ST_ACTIVE) || (next_state == PSRM_ST_STANDBY);
            pll_en <= (next_state == PSRM_ST_ACTIVE) || (next_state == PSRM_ST_STANDBY);
            pins_hold <= (next_state == PSRM_ST_STANDBY) || (next_state == PSRM_ST_SLEEP);
            host_if_en <= (next_state != PSRM_ST_INIT);
            regulator_on <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// file: psrm_host.sv
// Host end of the power-state and reset manager link.
// Assumes supplies are reported stable by supply_ok; long counts are parameters.
`default_nettype none
`include "psrm_regs.svh"

module psrm_host
    import psrm_pkg::*;
#(
    parameter int SETTLE_CYC = `PSRM_SUPPLY_SETTLE_CYC,
    parameter int RST_LOW_CYC = `PSRM_RST_LOW_CYC
) (
    input wire logic clk,          // System clock.
    input wire logic reset_n,      // Asynchronous reset, active low.
    psrm_link_if.host link,        // Link to the device.
    input wire logic supply_ok,    // Core supply group up.
    input wire logic hw_reset,     // Pulse: request a pin reset.
    input wire logic req_valid,    // Power command request.
    input wire psrm_cmd_t req_code, // Requested command code.
    output logic req_ready,        // Request taken this cycle.
    output logic rst_done          // Reset pin released.
);
    initial begin
        if (SETTLE_CYC < RST_LOW_CYC || RST_LOW_CYC < 1) begin
            $error("psrm_host: SETTLE_CYC must cover RST_LOW_CYC.");
        end
    end

    localparam int CW = $clog2(SETTLE_CYC + 1);
    logic [CW-1:0] count;
    logic pin_low;
    logic [1:0] code;
    logic valid;

    // ------------------------------------------------------------------------
    // Reset pin sequencing
    // ------------------------------------------------------------------------
    // Hold the pin low until supplies have settled, or for a requested pulse.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_low <= 1'b1;
            count <= '0;
        end else if (hw_reset) begin
            pin_low <= 1'b1;
            count <= CW'(SETTLE_CYC - RST_LOW_CYC);
        end else if (!supply_ok) begin
            pin_low <= 1'b1;
            count <= '0;
        end else if (pin_low) begin
            if (count == CW'(SETTLE_CYC)) begin
                pin_low <= 1'b0;
            end else begin
                count <= count + CW'(1);
            end
        end
    end

    assign link.rst_pin_n = ~pin_low;
    assign rst_done = ~pin_low;

    // ------------------------------------------------------------------------
    // Command strobe
    // ------------------------------------------------------------------------
    assign req_ready = !valid && !pin_low;

    // Present one command until the device takes it.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            valid <= 1'b0;
            code <= 2'h0;
        end else if (req_valid && req_ready) begin
            valid <= 1'b1;
            code <= req_code;
        end else if (valid && link.cmd_ready) begin
            valid <= 1'b0;
        end
    end

    assign link.cmd_valid = valid;
    assign link.cmd_code = code;
endmodule

`default_nettype wire

// file: psrm_monitor.sv
// Checker for the power-state link and the device's power controls.
// Assumes one clock domain; the testbench instantiates it beside the link interface.
`default_nettype none

module psrm_monitor
    import psrm_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic reset_n, // Power-on reset, active low.
    input wire logic rst_pin_n, // Reset pin, active low.
    input wire logic cmd_valid, // Command strobe.
    input wire logic [1:0] cmd_code, // Command code.
    input wire logic cmd_ready, // Device accepts commands.
    input wire psrm_state_e state, // Present power state.
    input wire logic core_reset_n, // Core reset, active low.
    input wire logic sys_clk_en, // Core clock enable.
    input wire logic engines_en, // Engines enabled.
    input wire logic engines_rst_n, // Engines reset, active low.
    input wire logic engines_pwr_on, // Engine power on.
    input wire logic dram_pd, // DRAM power-down.
    input wire logic dram_self_refresh, // DRAM self-refresh.
    input wire logic ddr_if_en, // DDR interface on.
    input wire logic pll_en, // PLLs on.
    input wire logic regs_clear, // Register clear pulse.
    input wire logic pins_hold, // Pins frozen.
    input wire logic host_if_en, // Host interface alive.
    input wire logic regulator_on // Core regulator on.
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------------
    // Maps a command code to the state that it selects.
    function automatic psrm_state_e st_of(input logic [1:0] c);
        return (c == 2'h0) ? PSRM_ST_ACTIVE : (c == 2'h1) ? PSRM_ST_STANDBY :
            (c == 2'h2) ? PSRM_ST_SLEEP : PSRM_ST_PDOWN;
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // A command is taken, names the present state, or leads into power-down.
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_same;
        s_take ##0 state == st_of(cmd_code);
    endsequence
    sequence s_to_pdown;
        s_take ##0 (cmd_code == 2'h3 && state != PSRM_ST_PDOWN);
    endsequence

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    // Command handling, control levels per state, start-up into sleep and the pin reset path.
    a_cmd_moves_state: assert property (s_take |=> state == st_of($past(cmd_code)))
        else $error("State does not follow the taken command.");
    a_same_cmd_quiet: assert property (s_same |=> $stable(state) && !regs_clear)
        else $error("Same-state command changed something.");
    a_engines_active: assert property (engines_en == (state == PSRM_ST_ACTIVE))
        else $error("Engines enabled outside the active state.");
    a_clock_gate: assert property (sys_clk_en == (state == PSRM_ST_ACTIVE))
        else $error("Core clock enable does not match the state.");
    a_sleep_dram_off: assert property (state == PSRM_ST_SLEEP |-> dram_self_refresh && !ddr_if_en && !pll_en)
        else $error("Sleep controls wrong.");
    a_pdown_held: assert property (state == PSRM_ST_PDOWN |->
        !engines_rst_n && !engines_pwr_on && host_if_en)
        else $error("Power-down controls wrong.");
    a_retain_regs: assert property (state inside {PSRM_ST_STANDBY, PSRM_ST_SLEEP} |-> engines_rst_n)
        else $error("Engines reset while registers must be kept.");
    a_regulator_stays: assert property (state == PSRM_ST_PDOWN |-> regulator_on)
        else $error("Regulator off in power-down.");
    a_pdown_clear: assert property (s_to_pdown |=> regs_clear ##1 !regs_clear)
        else $error("Register clear missing on power-down entry.");
    a_clear_cause: assert property (regs_clear |-> state == PSRM_ST_PDOWN && $past(state) != PSRM_ST_PDOWN)
        else $error("Register clear without power-down entry.");
    a_pins_frozen: assert property (pins_hold == (state inside {PSRM_ST_STANDBY, PSRM_ST_SLEEP}))
        else $error("Pin hold does not match the state.");
    a_dram_pd_standby: assert property (dram_pd |-> state == PSRM_ST_STANDBY)
        else $error("DRAM power-down outside standby.");
    a_init_to_sleep: assert property (state == PSRM_ST_INIT ##1 state != PSRM_ST_INIT |->
        state == PSRM_ST_SLEEP)
        else $error("Start-up did not end in sleep.");
    a_pin_reset: assert property (!rst_pin_n [*8] |-> ##[0:2] (!core_reset_n && state == PSRM_ST_INIT))
        else $error("Long reset pin low did not reset the device.");
endmodule

`default_nettype wire

// file: psrm_test.sv
// Testbench joining host and device ends through the link interface.
// Assumes the short counts below; all checks derive from them.
`default_nettype none

module psrm_test
    import psrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------------
    logic clk = 1'b0;
    logic reset_n, supply_ok, hw_reset, req_valid, dram_busy, req_ready, rst_done;
    logic core_reset_n, osc_ready, sys_clk_en, engines_en, engines_rst_n, engines_pwr_on;
    logic dram_pd, dram_self_refresh, ddr_if_en, pll_en, regs_clear, pins_hold, host_if_en, regulator_on;
    psrm_cmd_t req_code;
    psrm_state_e st;
    int n_fail = 0;
    int n_tests = 0;
    int n_clr = 0;
    psrm_cmd_t seq [9] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
    psrm_state_e exp_st [9] = '{PSRM_ST_ACTIVE, PSRM_ST_STANDBY, PSRM_ST_STANDBY, PSRM_ST_ACTIVE,
        PSRM_ST_SLEEP, PSRM_ST_SLEEP, PSRM_ST_PDOWN, PSRM_ST_PDOWN, PSRM_ST_ACTIVE};

    // Clock of 8 ns period.
    always #4 clk = ~clk;

    psrm_link_if psrm_link_if_i ();
    psrm_device #(.RST_LOW_CYC(8), .OSC_MASK_CYC(4), .DRAM_IDLE_CYC(8)) psrm_device_i (
        .clk(clk), .reset_n(reset_n), .link(psrm_link_if_i.dev), .dram_busy(dram_busy),
        .core_reset_n(core_reset_n), .osc_ready(osc_ready), .sys_clk_en(sys_clk_en), .engines_en(engines_en),
        .engines_rst_n(engines_rst_n), .engines_pwr_on(engines_pwr_on), .dram_pd(dram_pd),
        .dram_self_refresh(dram_self_refresh), .ddr_if_en(ddr_if_en), .pll_en(pll_en), .regs_clear(regs_clear),
        .pins_hold(pins_hold), .host_if_en(host_if_en), .regulator_on(regulator_on), .state(st));
    psrm_host #(.SETTLE_CYC(40), .RST_LOW_CYC(8)) psrm_host_i (
        .clk(clk), .reset_n(reset_n), .link(psrm_link_if_i.host), .supply_ok(supply_ok), .hw_reset(hw_reset),
        .req_valid(req_valid), .req_code(req_code), .req_ready(req_ready), .rst_done(rst_done));
    psrm_monitor psrm_monitor_i (
        .clk(clk), .reset_n(reset_n), .rst_pin_n(psrm_link_if_i.rst_pin_n), .cmd_valid(psrm_link_if_i.cmd_valid),
        .cmd_code(psrm_link_if_i.cmd_code), .cmd_ready(psrm_link_if_i.cmd_ready), .state(st),
        .core_reset_n(core_reset_n), .sys_clk_en(sys_clk_en), .engines_en(engines_en),
        .engines_rst_n(engines_rst_n), .engines_pwr_on(engines_pwr_on), .dram_pd(dram_pd),
        .dram_self_refresh(dram_self_refresh), .ddr_if_en(ddr_if_en), .pll_en(pll_en), .regs_clear(regs_clear),
        .pins_hold(pins_hold), .host_if_en(host_if_en), .regulator_on(regulator_on));

    // Counts register clear pulses.
    always @(posedge clk) begin
        if (regs_clear === 1'b1) n_clr <= n_clr + 1;
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    // Compare tasks for single bits and for the state.
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_state(input psrm_state_e exp, input psrm_state_e got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] state expected %h seen %h", exp, got);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Waits a bounded time for a state; a timeout ends the run.
    task automatic wait_state(input psrm_state_e s, input int lim);
        for (int i = 0; i < lim && st !== s; i++) @(negedge clk);
        if (st !== s) begin
            n_fail++;
            $display("[ERR] state wait expected %h seen %h", s, st);
            conclude();
        end
    endtask

    // Issues one host command and waits until the device has applied it.
    task automatic command(input psrm_cmd_t c);
        @(posedge clk);
        req_valid <= 1'b1;
        req_code <= c;
        @(negedge clk);
        for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clk);
        chk_bit("req_ready", 1'b1, req_ready);
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (2) @(negedge clk);
    endtask

    // Checks clock, engine enable, pin hold and regulator levels for every state, plus the extra levels of standby, sleep and power-down.
    task automatic expect_state(input psrm_state_e s);
        chk_state(s, st);
        chk_bit("sys_clk_en", s == PSRM_ST_ACTIVE, sys_clk_en);
        chk_bit("engines_en", s == PSRM_ST_ACTIVE, engines_en);
        chk_bit("pins_hold", s inside {PSRM_ST_STANDBY, PSRM_ST_SLEEP}, pins_hold);
        chk_bit("regulator_on", 1'b1, regulator_on);
        if (s inside {PSRM_ST_STANDBY, PSRM_ST_SLEEP}) begin
            chk_bit("engines_rst_n kept", 1'b1, engines_rst_n);
        end
        if (s == PSRM_ST_SLEEP) begin
            chk_bit("dram_self_refresh", 1'b1, dram_self_refresh);
            chk_bit("pll_en", 1'b0, pll_en);
            chk_bit("ddr_if_en", 1'b0, ddr_if_en);
        end
        if (s == PSRM_ST_PDOWN) begin
            chk_bit("engines_rst_n", 1'b0, engines_rst_n);
            chk_bit("engines_pwr_on", 1'b0, engines_pwr_on);
            chk_bit("host_if_en", 1'b1, host_if_en);
        end
    endtask

    // Power-on reset, then start-up into sleep.
    task automatic boot();
        @(posedge clk);
        reset_n <= 1'b0;
        supply_ok <= 1'b0;
        repeat (4) @(posedge clk);
        chk_state(PSRM_ST_INIT, st);
        chk_bit("core_reset_n", 1'b0, core_reset_n);
        reset_n <= 1'b1;
        supply_ok <= 1'b1;
        repeat (30) @(negedge clk);
        chk_bit("rst_done early", 1'b0, rst_done);
        wait_state(PSRM_ST_SLEEP, 200);
        chk_bit("rst_done", 1'b1, rst_done);
        chk_bit("osc_ready", 1'b1, osc_ready);
        expect_state(PSRM_ST_SLEEP);
        $display("test boot done, mismatches %0d", n_fail);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    // Runs every command, standby memory idling, a pin reset and a second power-on.
    initial begin
        reset_n = 1'b0;
        supply_ok = 1'b0;
        hw_reset = 1'b0;
        req_valid = 1'b0;
        req_code = 2'h0;
        dram_busy = 1'b1;
        boot();
        foreach (seq[k]) begin
            command(seq[k]);
            expect_state(exp_st[k]);
        end
        chk_bit("one register clear", 1'b1, n_clr == 1);
        $display("test commands done, mismatches %0d", n_fail);
        command(2'h1);
        repeat (12) @(negedge clk);
        chk_bit("dram_pd while busy", 1'b0, dram_pd);
        @(posedge clk);
        dram_busy <= 1'b0;
        for (int i = 0; i < 20 && dram_pd !== 1'b1; i++) @(negedge clk);
        chk_bit("dram_pd when idle", 1'b1, dram_pd);
        @(posedge clk);
        dram_busy <= 1'b1;
        $display("test standby memory done, mismatches %0d", n_fail);
        command(2'h0);
        @(posedge clk);
        hw_reset <= 1'b1;
        @(posedge clk);
        hw_reset <= 1'b0;
        wait_state(PSRM_ST_INIT, 30);
        wait_state(PSRM_ST_SLEEP, 200);
        expect_state(PSRM_ST_SLEEP);
        $display("test pin reset done, mismatches %0d", n_fail);
        command(2'h0);
        boot();
        conclude();
    end

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("[ERR] run length expected below 20000 cycles seen 20000");
        conclude();
    end
endmodule

`default_nettype wire
